// ==== verilog/uga_pkg.sv ====
// Purpose: constants, types and state layout of the multipurpose pin and notification block
// Assumes: AXI4-Lite register access, 40 MHz core clock, synchronous active-high reset
// Notes: all fields of every register sit in byte lane 0; the upper bits read as zero
// What this block does
// - mode 000 makes all six pins software general purpose pins.
// - mode 001 turns pin 4 into CTS# input, pin 5 into RTS# output.
// - mode 010 turns pin 2 into DSR# input, pin 3 into DTR# output.
// - mode 011 drives pin 5 as transceiver enable while transmitting.
// - mode 100 drives pin 5 as transceiver enable while transmitting after address match.
// - mode bit 3 picks transceiver enable polarity: 0 low, 1 high during transmit.
// - direction bit 0 input, 1 output, unless the mode fixes the pin.
// - set register write drives output pins to written value; input pins ignore it.
// - clear register write drives low each output pin written as 1.
// - status register reads the present level of all six pins.
// - mask bit 0 lets a pin change trigger a notification; 1 suppresses it.
// - masking leaves status alone; packets still carry masked pin levels.
// - format bit 0 picks standard layout, 1 the layout with pin levels.
// - packet opens with request type 10100001 then notification code 20.
// - then value 0, index 0, length 2, two data bytes; ten bytes total.
// - standard data: overrun D6 parity D5 framing D4 ring D3 break D2 DSR D1 CD D0.
// - custom data adds pins 5,4,3,0 at 14..11, pin 2 at 9, pin 1 at 8.
// - pull-up bits 5..0 switch pull-ups of the matching pins.
// - pull-up bit 6 switches the receive pin pull-up; avoid pull-up plus pull-down.
// - reserved mode bits are written as zero and read values are ignored.
// - transceiver enable holds the programmed bit times before turning to receive.
package uga_pkg;
    localparam logic [7:0] OFS_FUNC = 8'h00;
    localparam logic [7:0] OFS_DIR = 8'h04;
    localparam logic [7:0] OFS_SET = 8'h08;
    localparam logic [7:0] OFS_CLR = 8'h0c;
    localparam logic [7:0] OFS_STAT = 8'h10;
    localparam logic [7:0] OFS_MASK = 8'h14;
    localparam logic [7:0] OFS_FMT = 8'h18;
    localparam logic [7:0] OFS_PULL = 8'h1c;
    localparam logic [7:0] OFS_TURN = 8'h20;

    localparam int POL_BIT = 3;
    localparam int FMT_CUSTOM_BIT = 0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    localparam logic [7:0] PKT_REQ_TYPE = 8'ha1;
    localparam logic [7:0] PKT_NOTIFY_CODE = 8'h20;
    localparam logic [15:0] PKT_VALUE = 16'h0000;
    localparam logic [15:0] PKT_INDEX = 16'h0000;
    localparam logic [15:0] PKT_LENGTH = 16'h0002;
    localparam logic [3:0] PKT_LAST_IDX = 4'h9;

    typedef enum logic [2:0] {
        MODE_GPIO = 3'b000,
        MODE_RTS_CTS = 3'b001,
        MODE_DTR_DSR = 3'b010,
        MODE_XCVR_TX = 3'b011,
        MODE_XCVR_ADDR = 3'b100
    } uga_mode_t;

    typedef enum logic {
        NS_IDLE = 1'b0,
        NS_SEND = 1'b1
    } uga_nstate_t;

    typedef struct packed {
        logic overrun;
        logic parity;
        logic framing;
        logic brk;
    } uga_uart_status_t;

    typedef struct packed {
        logic [5:0] sync1;
        logic [5:0] sync2;
        logic [5:0] prev;
        logic [3:0] func;
        logic [5:0] dir;
        logic [5:0] out_latch;
        logic [5:0] mask;
        logic fmt;
        logic [6:0] pull;
        logic [3:0] turn;
        logic [5:0] pin_out;
        logic [5:0] pin_oe;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [7:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [11:0] rdata;
        logic [3:0] hold_cnt;
        logic pending;
        uga_nstate_t nstate;
        logic [3:0] byte_idx;
        logic [15:0] data_field;
        logic [7:0] note_byte;
    } uga_state_t;

    localparam uga_state_t STATE_RESET = '0;
endpackage

// ==== verilog/uga_pin_notify.sv ====
// Purpose: six multipurpose pins, their registers, and the serial-state notification packet
// Assumes: UART datapath signals come from logic on CLK; pin inputs are asynchronous
// Notes: the notification leaves as a byte stream with valid/ready toward the USB engine
`timescale 1ns/10ps
module uga_pin_notify (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [5:0] PIN_IN,
    output logic [5:0] PIN_OUT,
    output logic [5:0] PIN_OE,
    output logic [6:0] PULLUP_EN,
    input wire logic UART_TX_ACTIVE,
    input wire logic UART_ADDR_MATCH,
    input wire logic UART_BIT_TICK,
    input wire logic RTS_REQ,
    input wire logic DTR_REQ,
    output logic CTS_ASSERTED,
    output logic DSR_ASSERTED,
    input wire uga_pkg::uga_uart_status_t UART_STATUS,
    input wire logic ERR_EVENT,
    output logic NOTE_VALID,
    output logic [7:0] NOTE_DATA,
    output logic NOTE_LAST,
    input wire logic NOTE_READY
);

    uga_pkg::uga_state_t s;
    uga_pkg::uga_state_t next_s;

    // byte of the notification packet at a given offset; words go low byte first
    function automatic logic [7:0] pkt_byte(input logic [3:0] idx, input logic [15:0] data);
        logic [7:0] b;
        b = 8'h00;
        unique case (idx)
            4'h0: b = uga_pkg::PKT_REQ_TYPE;
            4'h1: b = uga_pkg::PKT_NOTIFY_CODE;
            4'h2: b = uga_pkg::PKT_VALUE[7:0];
            4'h3: b = uga_pkg::PKT_VALUE[15:8];
            4'h4: b = uga_pkg::PKT_INDEX[7:0];
            4'h5: b = uga_pkg::PKT_INDEX[15:8];
            4'h6: b = uga_pkg::PKT_LENGTH[7:0];
            4'h7: b = uga_pkg::PKT_LENGTH[15:8];
            4'h8: b = data[7:0];
            4'h9: b = data[15:8];
            default: b = 8'h00;
        endcase
        return b;
    endfunction

    logic [2:0] mode_code;
    logic xcvr_raw;
    logic xcvr_en;
    logic [5:0] drv_out;
    logic [5:0] drv_oe;
    logic [5:0] change;
    logic note_event;
    logic [15:0] std_field;
    logic [15:0] custom_field;
    logic [11:0] rd_value;
    logic rd_hit;
    logic wr_hit;
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic do_write;
    logic note_take;

    assign mode_code = s.func[2:0];

    // ready is withheld while a response is owed, so one write is in flight at most
    assign S_AXI_AWREADY = ~s.aw_got & ~s.bvalid;
    assign S_AXI_WREADY = ~s.w_got & ~s.bvalid;
    assign S_AXI_ARREADY = ~s.rvalid;
    assign S_AXI_BVALID = s.bvalid;
    assign S_AXI_BRESP = s.bresp;
    assign S_AXI_RVALID = s.rvalid;
    assign S_AXI_RRESP = s.rresp;
    assign S_AXI_RDATA = {20'h00000, s.rdata};

    assign PIN_OUT = s.pin_out;
    assign PIN_OE = s.pin_oe;
    assign PULLUP_EN = s.pull;

    assign NOTE_VALID = (s.nstate == uga_pkg::NS_SEND);
    assign NOTE_DATA = s.note_byte;
    assign NOTE_LAST = NOTE_VALID & (s.byte_idx == uga_pkg::PKT_LAST_IDX);

    // the flow control engine decides whether to honour these per its own mode
    assign CTS_ASSERTED = (mode_code == uga_pkg::MODE_RTS_CTS) & ~s.sync2[4];
    assign DSR_ASSERTED = (mode_code == uga_pkg::MODE_DTR_DSR) & ~s.sync2[2];

    assign aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
    assign w_take = S_AXI_WVALID & S_AXI_WREADY;
    assign ar_take = S_AXI_ARVALID & S_AXI_ARREADY;
    assign do_write = s.aw_got & s.w_got & ~s.bvalid;
    assign note_take = NOTE_VALID & NOTE_READY;

    // modem lines are active low on the pins; ring, carrier and DSR report asserted as 1
    assign std_field = {9'h000, UART_STATUS.overrun, UART_STATUS.parity, UART_STATUS.framing,
                        ~s.sync2[0], UART_STATUS.brk, ~s.sync2[2], ~s.sync2[1]};
    assign custom_field = {1'b0, s.sync2[5], s.sync2[4], s.sync2[3], s.sync2[0], 1'b0,
                           s.sync2[2], s.sync2[1], 1'b0, std_field[6:0]};

    // only unmasked pins raise an event; masked ones still travel in the data field
    assign change = (s.sync2 ^ s.prev) & ~s.mask;
    assign note_event = (|change) | ERR_EVENT;

    // transceiver enable stays on while the turnaround count runs down
    assign xcvr_en = xcvr_raw | (s.hold_cnt != 4'h0);

    always_comb
    begin
        xcvr_raw = 1'b0;
        unique case (mode_code)
            uga_pkg::MODE_XCVR_TX: xcvr_raw = UART_TX_ACTIVE;
            uga_pkg::MODE_XCVR_ADDR: xcvr_raw = UART_TX_ACTIVE & UART_ADDR_MATCH;
            default: xcvr_raw = 1'b0;
        endcase
    end

    always_comb
    begin
        drv_out = s.out_latch;
        drv_oe = s.dir;
        unique case (mode_code)
            uga_pkg::MODE_GPIO:
            begin
                drv_out = s.out_latch;
            end
            uga_pkg::MODE_RTS_CTS:
            begin
                drv_oe[4] = 1'b0;
                drv_oe[5] = 1'b1;
                drv_out[5] = ~RTS_REQ;
            end
            uga_pkg::MODE_DTR_DSR:
            begin
                drv_oe[2] = 1'b0;
                drv_oe[3] = 1'b1;
                drv_out[3] = ~DTR_REQ;
            end
            uga_pkg::MODE_XCVR_TX, uga_pkg::MODE_XCVR_ADDR:
            begin
                drv_oe[5] = 1'b1;
                drv_out[5] = s.func[uga_pkg::POL_BIT] ? xcvr_en : ~xcvr_en;
            end
            // codes 101..111 are undefined and fall back to plain pins
            default:
            begin
                drv_out = s.out_latch;
            end
        endcase
    end

    always_comb
    begin
        rd_value = 12'h000;
        rd_hit = 1'b1;
        unique case (S_AXI_ARADDR)
            // reserved mode bits read as zero, software ignores them anyway
            uga_pkg::OFS_FUNC: rd_value = {8'h00, s.func};
            uga_pkg::OFS_DIR: rd_value = {6'h00, s.dir};
            uga_pkg::OFS_SET: rd_value = {6'h00, s.out_latch};
            uga_pkg::OFS_CLR: rd_value = 12'h000;
            uga_pkg::OFS_STAT: rd_value = {6'h00, s.sync2};
            uga_pkg::OFS_MASK: rd_value = {6'h00, s.mask};
            uga_pkg::OFS_FMT: rd_value = {11'h000, s.fmt};
            uga_pkg::OFS_PULL: rd_value = {5'h00, s.pull};
            uga_pkg::OFS_TURN: rd_value = {8'h00, s.turn};
            default: rd_hit = 1'b0;
        endcase
    end

    always_comb
    begin
        wr_hit = 1'b1;
        unique case (s.aw_addr)
            uga_pkg::OFS_FUNC, uga_pkg::OFS_DIR, uga_pkg::OFS_SET, uga_pkg::OFS_CLR,
            uga_pkg::OFS_MASK, uga_pkg::OFS_FMT, uga_pkg::OFS_PULL, uga_pkg::OFS_TURN:
                wr_hit = 1'b1;
            // status is read-only: a write there is accepted and dropped
            uga_pkg::OFS_STAT: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_comb
    begin
        next_s = s;

        // two-flop synchroniser, then one more stage for change detection
        next_s.sync1 = PIN_IN;
        next_s.sync2 = s.sync1;
        next_s.prev = s.sync2;

        if (aw_take)
        begin
            next_s.aw_got = 1'b1;
            next_s.aw_addr = S_AXI_AWADDR;
        end
        if (w_take)
        begin
            next_s.w_got = 1'b1;
            next_s.wdata = S_AXI_WDATA[7:0];
            next_s.wstrb0 = S_AXI_WSTRB[0];
        end
        if (s.bvalid & S_AXI_BREADY)
        begin
            next_s.bvalid = 1'b0;
        end
        if (do_write)
        begin
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = wr_hit ? uga_pkg::RESP_OKAY : uga_pkg::RESP_DECERR;
            if (s.wstrb0)
            begin
                unique case (s.aw_addr)
                    uga_pkg::OFS_FUNC: next_s.func = s.wdata[3:0];
                    uga_pkg::OFS_DIR: next_s.dir = s.wdata[5:0];
                    uga_pkg::OFS_SET:
                        next_s.out_latch = (s.wdata[5:0] & s.dir) |
                                           (s.out_latch & ~s.dir);
                    uga_pkg::OFS_CLR: next_s.out_latch = s.out_latch & ~s.wdata[5:0];
                    uga_pkg::OFS_MASK: next_s.mask = s.wdata[5:0];
                    uga_pkg::OFS_FMT: next_s.fmt = s.wdata[uga_pkg::FMT_CUSTOM_BIT];
                    uga_pkg::OFS_PULL: next_s.pull = s.wdata[6:0];
                    uga_pkg::OFS_TURN: next_s.turn = s.wdata[3:0];
                    default: next_s.func = s.func;
                endcase
            end
        end

        if (s.rvalid & S_AXI_RREADY)
        begin
            next_s.rvalid = 1'b0;
        end
        if (ar_take)
        begin
            next_s.rvalid = 1'b1;
            next_s.rdata = rd_value;
            next_s.rresp = rd_hit ? uga_pkg::RESP_OKAY : uga_pkg::RESP_DECERR;
        end

        next_s.pin_out = drv_out;
        next_s.pin_oe = drv_oe;

        // reload while the raw enable is on, count bit ticks after it drops
        if (xcvr_raw)
        begin
            next_s.hold_cnt = s.turn;
        end
        else if (UART_BIT_TICK && (s.hold_cnt != 4'h0))
        begin
            next_s.hold_cnt = s.hold_cnt - 4'h1;
        end

        // a new event in the capture cycle keeps pending set
        if (note_event)
        begin
            next_s.pending = 1'b1;
        end
        else if (s.nstate == uga_pkg::NS_IDLE && s.pending)
        begin
            next_s.pending = 1'b0;
        end

        unique case (s.nstate)
            uga_pkg::NS_IDLE:
            begin
                if (s.pending)
                begin
                    next_s.data_field = s.fmt ? custom_field : std_field;
                    next_s.byte_idx = 4'h0;
                    next_s.note_byte = uga_pkg::PKT_REQ_TYPE;
                    next_s.nstate = uga_pkg::NS_SEND;
                end
            end
            uga_pkg::NS_SEND:
            begin
                if (note_take)
                begin
                    if (s.byte_idx == uga_pkg::PKT_LAST_IDX)
                    begin
                        next_s.nstate = uga_pkg::NS_IDLE;
                    end
                    else
                    begin
                        next_s.byte_idx = s.byte_idx + 4'h1;
                        next_s.note_byte = pkt_byte(s.byte_idx + 4'h1, s.data_field);
                    end
                end
            end
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            s <= uga_pkg::STATE_RESET;
        end
        else
        begin
            s <= next_s;
        end
    end

endmodule

// ==== testbench/uga_pin_notify_monitor.sv ====
// Purpose: port checks of the pin and notification block
// Assumes: one clock CLK, synchronous active-high SYS_RST
// Notes: bound to the block at the foot of this file
`timescale 1ns/10ps
module uga_pin_notify_monitor (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [5:0] PIN_OE,
    input wire logic CTS_ASSERTED,
    input wire logic DSR_ASSERTED,
    input wire logic ERR_EVENT,
    input wire logic NOTE_VALID,
    input wire logic [7:0] NOTE_DATA,
    input wire logic NOTE_LAST,
    input wire logic NOTE_READY
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    a_first_byte: assert property ($rose(NOTE_VALID) |-> NOTE_DATA == 8'ha1)
        else $error("packet opens with a wrong byte");
    // data bytes keep bit 7 low, so a1 only ever stands at byte 0
    a_code_byte: assert property (NOTE_VALID && NOTE_READY && NOTE_DATA == 8'ha1
        |=> NOTE_DATA == 8'h20)
        else $error("notification code missing");
    a_byte_stall: assert property (NOTE_VALID && !NOTE_READY
        |=> NOTE_VALID && $stable(NOTE_DATA))
        else $error("byte changed while stalled");
    a_gap_last: assert property (NOTE_VALID && NOTE_READY && NOTE_LAST |=> !NOTE_VALID)
        else $error("no idle cycle after last byte");
    a_err_packet: assert property (ERR_EVENT |-> ##[1:40] $rose(NOTE_VALID))
        else $error("event gave no packet");
    a_cts_input: assert property (CTS_ASSERTED |-> !PIN_OE[4])
        else $error("clear-to-send pin driven");
    a_dsr_input: assert property (DSR_ASSERTED |-> !PIN_OE[2])
        else $error("data-set-ready pin driven");
    a_read_upper: assert property (S_AXI_RVALID
        |-> S_AXI_RDATA[31:12] == 20'h0 && !S_AXI_ARREADY)
        else $error("read upper bits or ready wrong");
endmodule
bind uga_pin_notify uga_pin_notify_monitor i_uga_pin_notify_monitor (.*);

// ==== testbench/uga_host_model.sv ====
// Purpose: host end that takes notification bytes
// Assumes: bytes move on NOTE_VALID and NOTE_READY high at a rising edge
// Notes: SLOW toggles ready every cycle; a packet counts only when byte 9 ends it
`timescale 1ns/10ps
module uga_host_model (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic SLOW,
    input wire logic NOTE_VALID,
    input wire logic [7:0] NOTE_DATA,
    input wire logic NOTE_LAST,
    output logic NOTE_READY,
    output logic [79:0] PKT,
    output logic [7:0] N_PKT
);
    logic [3:0] idx;
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            NOTE_READY <= 1'b1;
            idx <= 4'h0;
            N_PKT <= 8'h0;
            PKT <= '0;
        end
        else
        begin
            NOTE_READY <= SLOW ? ~NOTE_READY : 1'b1;
            if (NOTE_VALID && NOTE_READY)
            begin
                PKT[idx*8 +: 8] <= NOTE_DATA;
                idx <= NOTE_LAST ? 4'h0 : idx + 4'h1;
                if (NOTE_LAST && idx == 4'h9) N_PKT <= N_PKT + 8'h1;
            end
        end
    end
endmodule

// ==== testbench/uga_pin_notify_tb_top.sv ====
// Purpose: self-checking bench of the pin and notification block
// Assumes: AXI4-Lite master tasks, host model on the notification stream
// Notes: pin wires resolve from the block's enables and the bench's external levels
`timescale 1ns/10ps
module uga_pin_notify_tb_top;
    logic CLK, SYS_RST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, SLOW;
    logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR, NOTE_DATA, N_PKT;
    logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
    logic [3:0] S_AXI_WSTRB;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rs;
    logic [5:0] PIN_IN, PIN_OUT, PIN_OE, ext;
    logic [6:0] PULLUP_EN;
    logic UART_TX_ACTIVE, UART_ADDR_MATCH, UART_BIT_TICK, RTS_REQ, DTR_REQ, CTS_ASSERTED;
    logic DSR_ASSERTED, ERR_EVENT, NOTE_VALID, NOTE_LAST, NOTE_READY;
    logic [79:0] PKT;
    logic [11:0] rd;
    uga_pkg::uga_uart_status_t UART_STATUS;
    int n_fail, samples_checked;
    typedef struct {logic [7:0] a; logic [11:0] w; logic [11:0] r; logic [1:0] resp;} uga_row_t;
    uga_row_t rows [12] = '{
        '{uga_pkg::OFS_MASK, 12'h03f, 12'h03f, uga_pkg::RESP_OKAY},
        '{uga_pkg::OFS_DIR, 12'h03f, 12'h03f, uga_pkg::RESP_OKAY},
        '{uga_pkg::OFS_SET, 12'h02a, 12'h02a, uga_pkg::RESP_OKAY},
        '{uga_pkg::OFS_CLR, 12'h00f, 12'h000, uga_pkg::RESP_OKAY},
        '{uga_pkg::OFS_STAT, 12'h0ff, 12'h020, uga_pkg::RESP_OKAY},
        '{uga_pkg::OFS_DIR, 12'h00f, 12'h00f, uga_pkg::RESP_OKAY},
        '{uga_pkg::OFS_SET, 12'h03f, 12'h02f, uga_pkg::RESP_OKAY},
        '{uga_pkg::OFS_FMT, 12'h001, 12'h001, uga_pkg::RESP_OKAY},
        '{uga_pkg::OFS_PULL, 12'h07f, 12'h07f, uga_pkg::RESP_OKAY},
        '{uga_pkg::OFS_TURN, 12'h005, 12'h005, uga_pkg::RESP_OKAY},
        '{uga_pkg::OFS_FUNC, 12'h008, 12'h008, uga_pkg::RESP_OKAY},
        '{8'h40, 12'h123, 12'h000, uga_pkg::RESP_DECERR}};
    assign PIN_IN = (PIN_OE & PIN_OUT) | (~PIN_OE & ext);
    uga_pin_notify i_uga_pin_notify (.*);
    uga_host_model i_uga_host_model (.*);
    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // each handshake is judged at the rising edge, on the values that stand there
    task automatic axw(input logic [7:0] a, input logic [11:0] d, output logic [1:0] r);
        logic done;
        done = 1'b0;
        r = 2'h0;
        @(posedge CLK);
        S_AXI_AWADDR <= a;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WDATA <= {20'h0, d};
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        while (!done)
        begin
            @(posedge CLK);
            if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
            if (S_AXI_BVALID)
            begin
                done = 1'b1;
                r = S_AXI_BRESP;
            end
        end
        S_AXI_BREADY <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a, output logic [11:0] d, output logic [1:0] r);
        logic done;
        done = 1'b0;
        d = 12'h000;
        r = 2'h0;
        @(posedge CLK);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        while (!done)
        begin
            @(posedge CLK);
            if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
            if (S_AXI_RVALID)
            begin
                done = 1'b1;
                d = S_AXI_RDATA[11:0];
                r = S_AXI_RRESP;
            end
        end
        S_AXI_RREADY <= 1'b0;
    endtask
    task automatic wait_pkt(input logic [7:0] n);
        int k;
        k = 0;
        while (N_PKT !== n && k < 200)
        begin
            @(posedge CLK);
            k++;
        end
        chk(N_PKT, n);
    endtask
    function automatic logic [15:0] exp_data(input logic [5:0] p, input logic f,
                                             input logic [3:0] s);
        exp_data = {9'h0, s[3], s[2], s[1], ~p[0], s[0], ~p[2], ~p[1]};
        if (f) exp_data[14:8] = {p[5], p[4], p[3], p[0], 1'b0, p[2], p[1]};
    endfunction
    task automatic mode(input logic [11:0] f);
        axw(uga_pkg::OFS_FUNC, f, rs);
        repeat (4) @(posedge CLK);
    endtask
    initial
    begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end
    initial
    begin
        repeat (20000) @(posedge CLK);
        n_fail++;
        stop_test();
    end
    initial
    begin
        {n_fail, samples_checked} = '0;
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY, SLOW} = '0;
        {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, ext, UART_STATUS} = '0;
        {UART_TX_ACTIVE, UART_ADDR_MATCH, UART_BIT_TICK, RTS_REQ, DTR_REQ, ERR_EVENT} = '0;
        S_AXI_WSTRB = 4'hf;
        SYS_RST = 1'b1;
        repeat (12) @(posedge CLK);
        SYS_RST <= 1'b0;
        foreach (rows[i])
        begin
            axw(rows[i].a, rows[i].w, rs);
            chk(rs, rows[i].resp);
            axr(rows[i].a, rd, rs);
            chk({rs, rd}, {rows[i].resp, rows[i].r});
        end
        axw(uga_pkg::OFS_CLR, 12'h001, rs);
        repeat (2) @(posedge CLK);
        chk({PULLUP_EN, PIN_OE, PIN_OUT[3:0]}, {7'h7f, 6'h0f, 4'he});
        ext <= 6'h15;
        repeat (4) @(posedge CLK);
        axr(uga_pkg::OFS_STAT, rd, rs);
        chk(rd, 12'h01e);
        chk(N_PKT, 8'h0);
        axw(uga_pkg::OFS_FMT, 12'h000, rs);
        axw(uga_pkg::OFS_MASK, 12'h02f, rs);
        UART_STATUS <= 4'b1010;
        ext <= 6'h05;
        wait_pkt(8'h1);
        chk(PKT, {exp_data(6'h0e, 1'b0, 4'b1010), 64'h0002_0000_0000_20a1});
        axw(uga_pkg::OFS_FMT, 12'h001, rs);
        UART_STATUS <= 4'b0101;
        SLOW <= 1'b1;
        ERR_EVENT <= 1'b1;
        @(posedge CLK);
        ERR_EVENT <= 1'b0;
        repeat (8) @(posedge CLK);
        ERR_EVENT <= 1'b1;
        @(posedge CLK);
        ERR_EVENT <= 1'b0;
        wait_pkt(8'h3);
        chk(PKT, {exp_data(6'h0e, 1'b1, 4'b0101), 64'h0002_0000_0000_20a1});
        axw(uga_pkg::OFS_MASK, 12'h03f, rs);
        axw(uga_pkg::OFS_DIR, 12'h000, rs);
        ext <= 6'h00;
        RTS_REQ <= 1'b1;
        DTR_REQ <= 1'b1;
        mode(12'h001);
        chk({CTS_ASSERTED, PIN_OE[4], PIN_OE[5], PIN_OUT[5]}, 4'b1010);
        mode(12'h002);
        chk({DSR_ASSERTED, CTS_ASSERTED, PIN_OE[3], PIN_OUT[3]}, 4'b1010);
        // no turnaround hold, so mode 100 starts from a released enable
        axw(uga_pkg::OFS_TURN, 12'h000, rs);
        UART_TX_ACTIVE <= 1'b1;
        mode(12'h00b);
        chk({PIN_OE[5], PIN_OUT[5]}, 2'b11);
        mode(12'h003);
        chk(PIN_OUT[5], 1'b0);
        mode(12'h00c);
        chk(PIN_OUT[5], 1'b0);
        UART_ADDR_MATCH <= 1'b1;
        repeat (4) @(posedge CLK);
        chk(PIN_OUT[5], 1'b1);
        axw(uga_pkg::OFS_TURN, 12'h002, rs);
        UART_TX_ACTIVE <= 1'b0;
        repeat (4) @(posedge CLK);
        chk(PIN_OUT[5], 1'b1);
        for (int t = 0; t < 2; t++)
        begin
            @(posedge CLK);
            UART_BIT_TICK <= 1'b1;
            @(posedge CLK);
            UART_BIT_TICK <= 1'b0;
            repeat (2) @(posedge CLK);
            chk(PIN_OUT[5], t == 0);
        end
        mode(12'h00d);
        chk(PIN_OE, 6'h00);
        S_AXI_WSTRB <= 4'he;
        axw(uga_pkg::OFS_FMT, 12'h000, rs);
        S_AXI_WSTRB <= 4'hf;
        axr(uga_pkg::OFS_FMT, rd, rs);
        chk({rs, rd}, {uga_pkg::RESP_OKAY, 12'h001});
        SYS_RST <= 1'b1;
        repeat (2) @(posedge CLK);
        SYS_RST <= 1'b0;
        @(posedge CLK);
        chk({PIN_OE, PIN_OUT, PULLUP_EN, NOTE_VALID, S_AXI_BVALID, S_AXI_RVALID}, '0);
        axr(uga_pkg::OFS_PULL, rd, rs);
        chk({rs, rd}, {uga_pkg::RESP_OKAY, 12'h000});
        stop_test();
    end
endmodule
